// [design/fpa_consts.vh]
// constants for the fixed-point alu with flags
`ifndef FPA_CONSTS_VH
`define FPA_CONSTS_VH

`define FPA_W 16
// flag bit positions in arith_flags_reg
`define FPA_F_ZERO 0
`define FPA_F_NEG 1
`define FPA_F_OVF 2
`define FPA_F_CARRY 3
`define FPA_F_XSIGN 4
`define FPA_F_QUOT 5
`define FPA_FLAGS_RST 6'h00
`define FPA_DATA_RST 16'h0000
`define FPA_SAT_POS 16'h7fff
`define FPA_SAT_NEG 16'h8000
// mode_status_reg bit positions
`define FPA_M_OVF_STICKY 2
`define FPA_M_SAT 3
`define FPA_MODE_RST 16'h0000
// register map, word addresses
`define FPA_A_CTRL 4'h0
`define FPA_A_XOP 4'h1
`define FPA_A_YOP 4'h2
`define FPA_A_FLAGS 4'h3
`define FPA_A_RESULT 4'h4
`define FPA_A_FEEDBACK 4'h5
`define FPA_A_MODE 4'h6
// operation codes
`define FPA_OP_ADD 5'h00
`define FPA_OP_ADDC 5'h01
`define FPA_OP_SUB 5'h02
`define FPA_OP_SUBB 5'h03
`define FPA_OP_RSUB 5'h04
`define FPA_OP_RSUBB 5'h05
`define FPA_OP_NEG 5'h06
`define FPA_OP_INC 5'h07
`define FPA_OP_DEC 5'h08
`define FPA_OP_AND 5'h09
`define FPA_OP_OR 5'h0a
`define FPA_OP_XOR 5'h0b
`define FPA_OP_NOT 5'h0c
`define FPA_OP_PASS 5'h0d
`define FPA_OP_PASSY 5'h0e
`define FPA_OP_ZERO 5'h0f
`define FPA_OP_TST 5'h10
`define FPA_OP_SET 5'h11
`define FPA_OP_CLR 5'h12
`define FPA_OP_TGL 5'h13
`define FPA_OP_ABS 5'h14
`define FPA_OP_DIVS 5'h15
`define FPA_OP_DIVQ 5'h16
// destinations
`define FPA_D_RESULT 2'h0
`define FPA_D_FEEDBACK 2'h1
`define FPA_D_NONE 2'h2
// y source: operand, feedback, constant
`define FPA_Y_OPND 2'h0
`define FPA_Y_FB 2'h1
`define FPA_Y_CONST 2'h2

`endif

// [design/fpa_alu.v]
// fixed-point alu with arithmetic flags and avalon-mm register slave
// Operation
// (RULE_01) sixteen-bit unit: two 16-bit operands X and Y, one 16-bit result
// (RULE_02) add, sub, carry/borrow, inc, dec, logic, bit ops, magnitude, pass, divide steps
// (RULE_03) zero flag is NOR of all result bits
// (RULE_04) negative flag is result sign bit
// (RULE_05) overflow is XOR of carries out of top two adder stages
// (RULE_06) carry flag is carry out of top adder stage
// (RULE_07) x-sign flag takes X sign, updated only by magnitude
// (RULE_08) quotient bit only from divide steps; they keep other flags
// (RULE_09) flags latch at end of cycle, visible next cycle
// (RULE_10) explicit flag register write takes effect one cycle late
// (RULE_11) arithmetic ops update zero, overflow, negative, carry; keep x-sign, quotient
// (RULE_12) logic, bit, not, pass update zero, negative; clear overflow, carry
// (RULE_13) magnitude updates zero, sets x-sign, clears overflow, negative, carry
// (RULE_14) flags identical whether result goes to result or feedback register
// (RULE_15) carry input is previous carry flag; borrow forms add carry minus one
// (RULE_16) result to result or feedback register; no-destination updates only flags
// (RULE_17) operands read at cycle start, results written at end
// (RULE_18) unconditional ops: any register for X and Y; Y may take feedback
// (RULE_19) conditional ops restrict X and Y register sets
// (RULE_20) with restricted X, Y may be an instruction constant
// (RULE_21) divide steps support non-restoring signed or unsigned division
// (RULE_22) sticky overflow mode holds overflow until explicitly cleared
// (RULE_23) saturate mode: overflowed result writes 0x7fff or 0x8000 by carry
// (RULE_24) sign divide step: XOR signs into quotient bit, shift pair left
// (RULE_25) quotient step adds if quotient bit set else subtracts, shifts in bit
// (RULE_26) reset clears all flags, result and feedback registers
`timescale 1ns/1ps
`default_nettype none
`include "fpa_consts.vh"

module fpa_alu (
    // clock and reset
    input wire clk,
    input wire rst,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // live state
    output reg [5:0] arith_flags_reg,
    output reg [15:0] alu_result_reg,
    output reg [15:0] alu_feedback_reg
);

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle per access so read data comes from flops

    reg ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    wire wr_go = avs_write & ack;
    wire lo_en = avs_byteenable[0];
    wire hi_en = avs_byteenable[1];

    // operand latches and instruction control
    reg [15:0] x_operand;
    reg [15:0] y_operand;
    reg [15:0] mode_status_reg;
    reg [4:0] op_code;
    reg [1:0] dest_sel;
    reg [1:0] y_sel;
    reg [3:0] bit_num;
    reg [15:0] const_val;

    // delayed flag write, held one cycle before it lands
    reg flag_wr_pend;
    reg [5:0] flag_wr_val;
    reg op_go;

    ////////////////////////////////////////////////////////////////////////
    // operand selection

    wire [15:0] x_in = x_operand; // see (RULE_17) (RULE_18)
    reg [15:0] y_in;
    always @* begin
        case (y_sel)
            `FPA_Y_FB: y_in = alu_feedback_reg; // see (RULE_18) (RULE_19)
            `FPA_Y_CONST: y_in = const_val; // see (RULE_20)
            default: y_in = y_operand;
        endcase
    end

    wire c_in = arith_flags_reg[`FPA_F_CARRY]; // see (RULE_15)
    wire q_in = arith_flags_reg[`FPA_F_QUOT];

    ////////////////////////////////////////////////////////////////////////
    // adder: operands a, b and carry feed a single 16-bit chain

    reg [15:0] add_a;
    reg [15:0] add_b;
    reg add_ci;
    reg is_arith;
    reg is_logic;
    reg [15:0] log_r;
    wire [15:0] bit_mask = 16'h0001 << bit_num;

    always @* begin
        add_a = x_in;
        add_b = y_in;
        add_ci = 1'b0;
        is_arith = 1'b1;
        is_logic = 1'b0;
        log_r = 16'h0000;
        case (op_code)
            `FPA_OP_ADD: add_ci = 1'b0;
            `FPA_OP_ADDC: add_ci = c_in; // see (RULE_15)
            `FPA_OP_SUB: begin
                add_b = ~y_in;
                add_ci = 1'b1;
            end
            `FPA_OP_SUBB: begin
                add_b = ~y_in;
                add_ci = c_in; // see (RULE_15)
            end
            `FPA_OP_RSUB: begin
                add_a = y_in;
                add_b = ~x_in;
                add_ci = 1'b1;
            end
            `FPA_OP_RSUBB: begin
                add_a = y_in;
                add_b = ~x_in;
                add_ci = c_in;
            end
            `FPA_OP_NEG: begin
                add_a = 16'h0000;
                add_b = ~x_in;
                add_ci = c_in;
            end
            `FPA_OP_INC: begin
                add_a = y_in;
                add_b = 16'h0000;
                add_ci = 1'b1;
            end
            `FPA_OP_DEC: begin
                add_a = y_in;
                add_b = 16'hffff;
            end
            `FPA_OP_ABS: begin
                add_a = 16'h0000;
                add_b = x_in[15] ? ~x_in : x_in;
                add_ci = x_in[15];
                is_arith = 1'b0;
            end
            `FPA_OP_DIVS: begin
                add_a = 16'h0000;
                add_b = y_in;
                is_arith = 1'b0;
            end
            `FPA_OP_DIVQ: begin
                // partial remainder in feedback, divisor on X
                add_a = alu_feedback_reg;
                add_b = q_in ? x_in : ~x_in; // see (RULE_25)
                add_ci = ~q_in;
                is_arith = 1'b0;
            end
            default: begin
                is_arith = 1'b0;
                is_logic = 1'b1;
                case (op_code)
                    `FPA_OP_AND: log_r = x_in & y_in;
                    `FPA_OP_OR: log_r = x_in | y_in;
                    `FPA_OP_XOR: log_r = x_in ^ y_in;
                    `FPA_OP_NOT: log_r = ~x_in;
                    `FPA_OP_PASS: log_r = x_in;
                    `FPA_OP_PASSY: log_r = y_in;
                    `FPA_OP_ZERO: log_r = 16'h0000;
                    `FPA_OP_TST: log_r = x_in & bit_mask;
                    `FPA_OP_SET: log_r = x_in | bit_mask;
                    `FPA_OP_CLR: log_r = x_in & ~bit_mask;
                    `FPA_OP_TGL: log_r = x_in ^ bit_mask;
                    default: log_r = 16'h0000;
                endcase
            end
        endcase
    end

    // split the chain so the carry into the top stage is visible
    wire [15:0] lo_sum = {1'b0, add_a[14:0]} + {1'b0, add_b[14:0]} + {15'h0000, add_ci};
    wire c14 = lo_sum[15];
    wire [1:0] hi_sum = {1'b0, add_a[15]} + {1'b0, add_b[15]} + {1'b0, c14};
    wire c15 = hi_sum[1]; // see (RULE_06)
    wire [15:0] sum = {hi_sum[0], lo_sum[14:0]};
    wire ovf = c15 ^ c14; // see (RULE_05)

    wire is_div = (op_code == `FPA_OP_DIVS) | (op_code == `FPA_OP_DIVQ);
    wire [15:0] alu_r = is_logic ? log_r : sum; // see (RULE_01) (RULE_02)

    ////////////////////////////////////////////////////////////////////////
    // flag generation, independent of destination

    reg [5:0] next_flags;
    reg next_quot;
    always @* begin
        next_flags = arith_flags_reg;
        // divide sign and quotient bits
        if (op_code == `FPA_OP_DIVS)
            next_quot = y_in[15] ^ x_in[15]; // see (RULE_24)
        else
            next_quot = ~(x_in[15] ^ sum[15]); // see (RULE_25)
        if (is_div) begin
            next_flags[`FPA_F_QUOT] = ~next_quot; // see (RULE_08) (RULE_21)
            if (op_code == `FPA_OP_DIVS)
                next_flags[`FPA_F_QUOT] = next_quot;
        end else begin
            next_flags[`FPA_F_ZERO] = ~|alu_r; // see (RULE_03) (RULE_14)
            if (op_code == `FPA_OP_ABS) begin
                next_flags[`FPA_F_NEG] = 1'b0; // see (RULE_13)
                next_flags[`FPA_F_CARRY] = 1'b0;
                next_flags[`FPA_F_XSIGN] = x_in[15]; // see (RULE_07)
                if (!mode_status_reg[`FPA_M_OVF_STICKY])
                    next_flags[`FPA_F_OVF] = 1'b0;
            end else begin
                next_flags[`FPA_F_NEG] = alu_r[15]; // see (RULE_04)
                next_flags[`FPA_F_CARRY] = is_arith & c15; // see (RULE_11) (RULE_12)
                if (is_arith & ovf)
                    next_flags[`FPA_F_OVF] = 1'b1;
                else if (!mode_status_reg[`FPA_M_OVF_STICKY])
                    next_flags[`FPA_F_OVF] = 1'b0; // see (RULE_22)
            end
        end
    end

    // saturation applies to the result register only
    reg [15:0] sat_r;
    always @* begin
        sat_r = alu_r;
        if (mode_status_reg[`FPA_M_SAT] && is_arith && next_flags[`FPA_F_OVF])
            sat_r = next_flags[`FPA_F_CARRY] ? `FPA_SAT_NEG : `FPA_SAT_POS; // see (RULE_23)
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
            x_operand <= `FPA_DATA_RST;
            y_operand <= `FPA_DATA_RST;
            mode_status_reg <= `FPA_MODE_RST;
            op_code <= `FPA_OP_ADD;
            dest_sel <= `FPA_D_NONE;
            y_sel <= `FPA_Y_OPND;
            bit_num <= 4'h0;
            const_val <= 16'h0000;
            op_go <= 1'b0;
            flag_wr_pend <= 1'b0;
            flag_wr_val <= `FPA_FLAGS_RST;
            arith_flags_reg <= `FPA_FLAGS_RST; // see (RULE_26)
            alu_result_reg <= `FPA_DATA_RST;
            alu_feedback_reg <= `FPA_DATA_RST;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
            op_go <= 1'b0;
            flag_wr_pend <= 1'b0;
            if (avs_read & ~ack) begin
                case (avs_address)
                    `FPA_A_CTRL: avs_readdata <= {3'h0, const_val, bit_num, y_sel,
                                                  dest_sel, op_code};
                    `FPA_A_XOP: avs_readdata <= {16'h0000, x_operand};
                    `FPA_A_YOP: avs_readdata <= {16'h0000, y_operand};
                    `FPA_A_FLAGS: avs_readdata <= {26'h0000000, arith_flags_reg};
                    `FPA_A_RESULT: avs_readdata <= {16'h0000, alu_result_reg};
                    `FPA_A_FEEDBACK: avs_readdata <= {16'h0000, alu_feedback_reg};
                    `FPA_A_MODE: avs_readdata <= {16'h0000, mode_status_reg};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            if (wr_go) begin
                case (avs_address)
                    `FPA_A_CTRL: begin
                        if (lo_en) begin
                            op_code <= avs_writedata[4:0];
                            dest_sel <= avs_writedata[6:5];
                        end
                        if (lo_en) y_sel <= avs_writedata[8:7];
                        if (hi_en) bit_num <= avs_writedata[12:9];
                        const_val <= avs_writedata[28:13];
                        op_go <= 1'b1;
                    end
                    `FPA_A_XOP: begin
                        if (lo_en) x_operand[7:0] <= avs_writedata[7:0];
                        if (hi_en) x_operand[15:8] <= avs_writedata[15:8];
                    end
                    `FPA_A_YOP: begin
                        if (lo_en) y_operand[7:0] <= avs_writedata[7:0];
                        if (hi_en) y_operand[15:8] <= avs_writedata[15:8];
                    end
                    `FPA_A_FLAGS: begin
                        flag_wr_pend <= lo_en; // see (RULE_10)
                        flag_wr_val <= avs_writedata[5:0];
                    end
                    `FPA_A_RESULT: if (lo_en) alu_result_reg <= avs_writedata[15:0];
                    `FPA_A_FEEDBACK: if (lo_en) alu_feedback_reg <= avs_writedata[15:0];
                    `FPA_A_MODE: begin
                        if (lo_en) mode_status_reg[7:0] <= avs_writedata[7:0];
                        if (hi_en) mode_status_reg[15:8] <= avs_writedata[15:8];
                    end
                    default: begin
                    end
                endcase
            end
            // an op issued one cycle after a flag write already sees the new flags
            if (flag_wr_pend)
                arith_flags_reg <= flag_wr_val; // see (RULE_10)
            else if (op_go)
                arith_flags_reg <= next_flags; // see (RULE_09)
            if (op_go) begin
                if (is_div) begin
                    // shift the feedback and low-dividend pair, quotient bit enters
                    alu_feedback_reg <= {sum[14:0], y_operand[15]}; // see (RULE_24) (RULE_25)
                    y_operand <= {y_operand[14:0],
                                  (op_code == `FPA_OP_DIVS) ? next_quot : next_quot};
                end else if (dest_sel == `FPA_D_RESULT)
                    alu_result_reg <= sat_r; // see (RULE_16) (RULE_23)
                else if (dest_sel == `FPA_D_FEEDBACK)
                    alu_feedback_reg <= alu_r; // see (RULE_16) (RULE_14)
            end
        end
    end

endmodule // fpa_alu
`default_nettype wire

// [test/fpa_seq.sv]
// bus master model standing in for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module fpa_seq (
    // clock and answer
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    // request
    output var logic [3:0] address,
    output var logic read,
    output var logic write,
    output var logic [31:0] writedata,
    output var logic [3:0] byteenable,
    output var logic hung
);
    initial begin
        {address, read, write, writedata, byteenable, hung} = 43'h0;
    end

    // holds the request until waitrequest is seen low; the wait is bounded
    task automatic req(input logic [3:0] a, input logic w, input logic [31:0] dv,
                       output logic [31:0] q);
        int i;
        @(posedge clk);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= dv;
        byteenable <= 4'hf;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 16);
        q = readdata;
        hung <= (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        // released address and data lines never keep the last value; byteenable stays 4'hf
        address <= ~a;
        writedata <= ~dv;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] dv);
        logic [31:0] q;
        req(a, 1'b1, dv, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        req(a, 1'b0, 32'h0, q);
    endtask
endmodule // fpa_seq
`default_nettype wire

// [test/fpa_alu_properties.sv]
// concurrent checks on the fixed-point alu ports
`timescale 1ns/1ps
`default_nettype none
`include "fpa_consts.vh"
module fpa_alu_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // live state
    input wire logic [5:0] arith_flags_reg,
    input wire logic [15:0] alu_result_reg,
    input wire logic [15:0] alu_feedback_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // shadow of operands and mode; y goes stale after a divide step shifts it
    logic [15:0] xr, yr, md;
    logic acc, ctl, ov;
    logic [4:0] op;
    logic [1:0] ds, ys;
    logic [16:0] sm;
    assign acc = avs_write && !avs_waitrequest;
    assign ctl = acc && avs_address == `FPA_A_CTRL;
    assign op = avs_writedata[4:0];
    assign ds = avs_writedata[6:5];
    assign ys = avs_writedata[8:7];
    assign sm = {1'b0, xr} + {1'b0, yr};
    assign ov = xr[15] == yr[15] && sm[15] != xr[15];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xr <= 16'h0000;
            yr <= 16'h0000;
            md <= 16'h0000;
        end else if (acc && avs_address == `FPA_A_XOP) begin
            xr <= avs_writedata[15:0];
        end else if (acc && avs_address == `FPA_A_YOP) begin
            yr <= avs_writedata[15:0];
        end else if (acc && avs_address == `FPA_A_MODE) begin
            md <= avs_writedata[15:0];
        end
    end
    ////////////////////////////////////////
    sequence s_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_late;
        $stable(arith_flags_reg) ##1 arith_flags_reg == $past(avs_writedata[5:0], 2);
    endsequence

    AST_WAIT: assert property ($rose(avs_read || avs_write) |-> s_wait)
        else $error("wait state count wrong");
    AST_ZERO: assert property (ctl && ds == 2'h0 && op <= 5'h14 && !md[3]
        |-> ##2 arith_flags_reg[0] == (alu_result_reg == 16'h0000))
        else $error("zero flag wrong");
    AST_NEG: assert property (ctl && ds == 2'h0 && op <= 5'h13 && !md[3]
        |-> ##2 arith_flags_reg[1] == alu_result_reg[15])
        else $error("negative flag wrong");
    AST_CARRY: assert property (ctl && op == 5'h00 && ys == 2'h0 && !md[2]
        |-> ##2 arith_flags_reg[3:2] == {sm[16], ov})
        else $error("carry or overflow wrong");
    AST_XSIGN: assert property (ctl && op != 5'h14 |-> ##2 $stable(arith_flags_reg[4]))
        else $error("x sign moved");
    AST_ABS: assert property (ctl && op == 5'h14 && !md[2]
        |-> ##2 arith_flags_reg[4:1] == {xr[15], 3'b000})
        else $error("magnitude flags wrong");
    AST_LOGIC: assert property (ctl && op inside {[5'h09:5'h13]} && !md[2]
        |-> ##2 arith_flags_reg[3:2] == 2'b00)
        else $error("logic op left carry or overflow");
    AST_DIV: assert property (ctl && op inside {5'h15, 5'h16}
        |-> ##2 $stable(arith_flags_reg[4:0]))
        else $error("divide step moved flags");
    AST_DIVS: assert property (ctl && op == 5'h15 && ys == 2'h1
        |-> ##2 arith_flags_reg[5] == (xr[15] ^ $past(alu_feedback_reg[15])))
        else $error("sign step quotient wrong");
    AST_LATE: assert property (acc && avs_address == `FPA_A_FLAGS && avs_byteenable[0]
        |=> s_late)
        else $error("flag write timing wrong");
    AST_NONE: assert property (ctl && ds == 2'h2 && op <= 5'h14
        |-> ##2 $stable(alu_result_reg) && $stable(alu_feedback_reg))
        else $error("no-destination op wrote");
    AST_SAT: assert property (ctl && op == 5'h00 && ys == 2'h0 && ds == 2'h0 && md[3] && ov
        |-> ##2 alu_result_reg == (sm[16] ? 16'h8000 : 16'h7fff))
        else $error("saturation wrong");
endmodule // fpa_alu_props
bind fpa_alu fpa_alu_props u_props (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .arith_flags_reg,
    .alu_result_reg, .alu_feedback_reg);
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the fixed-point alu
`timescale 1ns/1ps
`default_nettype none
`include "fpa_consts.vh"
module tb;
    logic clk, rst, rd_s, wr_s, wq, hung;
    logic [3:0] a, be, bn, f;
    logic [31:0] wd, rdat, d;
    logic [5:0] fl;
    logic [15:0] res, fb, x, y, r;
    logic [4:0] op;
    int n_fail, samples_checked;
    // op, bit, x, y, result, flags {carry, overflow, negative, zero}
    logic [60:0] rows [21] = '{
        {5'h00, 4'h0, 16'h7fff, 16'h0001, 16'h8000, 4'h6}, {5'h00, 4'h0, 16'hffff, 16'h0001, 16'h0000, 4'h9},
        {5'h01, 4'h0, 16'h0001, 16'h0001, 16'h0003, 4'h0}, {5'h02, 4'h0, 16'h0005, 16'h0007, 16'hfffe, 4'h2},
        {5'h03, 4'h0, 16'h0005, 16'h0003, 16'h0001, 4'h8}, {5'h04, 4'h0, 16'h0001, 16'h0003, 16'h0002, 4'h8},
        {5'h06, 4'h0, 16'h0005, 16'h0000, 16'hfffb, 4'h2}, {5'h05, 4'h0, 16'h0000, 16'h0000, 16'hffff, 4'h2},
        {5'h07, 4'h0, 16'h0000, 16'hffff, 16'h0000, 4'h9}, {5'h08, 4'h0, 16'h0000, 16'h8000, 16'h7fff, 4'hc},
        {5'h09, 4'h0, 16'hf0f0, 16'hff00, 16'hf000, 4'h2}, {5'h0a, 4'h0, 16'h0000, 16'h0000, 16'h0000, 4'h1},
        {5'h0b, 4'h0, 16'haaaa, 16'h5555, 16'hffff, 4'h2}, {5'h0c, 4'h0, 16'hffff, 16'h0000, 16'h0000, 4'h1},
        {5'h0d, 4'h0, 16'h8001, 16'h0000, 16'h8001, 4'h2}, {5'h0e, 4'h0, 16'h0000, 16'h1234, 16'h1234, 4'h0},
        {5'h0f, 4'h0, 16'h0005, 16'h0000, 16'h0000, 4'h1}, {5'h10, 4'h3, 16'h0008, 16'h0000, 16'h0008, 4'h0},
        {5'h11, 4'h4, 16'h0000, 16'h0000, 16'h0010, 4'h0}, {5'h12, 4'hf, 16'h8000, 16'h0000, 16'h0000, 4'h1},
        {5'h13, 4'hf, 16'h0000, 16'h0000, 16'h8000, 4'h2}};

    fpa_alu dut (.clk(clk), .rst(rst), .avs_address(a), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
        .arith_flags_reg(fl), .alu_result_reg(res), .alu_feedback_reg(fb));
    fpa_seq u_seq (.clk(clk), .waitrequest(wq), .readdata(rdat), .address(a), .read(rd_s),
        .write(wr_s), .writedata(wd), .byteenable(be), .hung(hung));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////
    // wide enough for flags, result and feedback compared together
    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the op lands one edge after the control write; look just past it
    task automatic run(input logic [31:0] c, input logic [15:0] xv, yv);
        u_seq.wr(`FPA_A_XOP, {16'h0000, xv});
        u_seq.wr(`FPA_A_YOP, {16'h0000, yv});
        u_seq.wr(`FPA_A_CTRL, c);
        @(posedge clk);
        #1;
    endtask

    always @(posedge hung) begin
        n_fail++;
        stop_test();
    end
    ////////////////////////////////////////
    initial begin
        n_fail = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            {op, bn, x, y, r, f} = rows[i];
            run({19'h0, bn, 4'h0, op}, x, y);
            cmp(res, r);
            cmp(fl, {2'b00, f});
            u_seq.rd(`FPA_A_RESULT, d);
            cmp(d, r);
        end
        run(32'h20, 16'h7fff, 16'h0001);
        cmp({res, fb}, 32'h80008000);
        cmp(fl, 6'h06);
        run(32'h40, 16'h0001, 16'h0001);
        cmp({fl, res, fb}, {6'h00, 32'h80008000});
        run(32'h80, 16'h0001, 16'h0000);
        cmp(res, 16'h8001);
        run(32'h20100, 16'h0001, 16'h0000);
        cmp(res, 16'h0011);
        u_seq.wr(`FPA_A_FLAGS, 32'h3f);
        #1;
        cmp(fl, 6'h00);
        @(posedge clk);
        #1;
        cmp(fl, 6'h3f);
        run(32'h14, 16'h8001, 16'h0000);
        cmp({fl, res}, {6'h30, 16'h7fff});
        run(32'h0, 16'h0001, 16'h0001);
        cmp(fl, 6'h30);
        u_seq.wr(`FPA_A_FLAGS, 32'h0);
        u_seq.wr(`FPA_A_FEEDBACK, 32'h8000);
        run(32'h95, 16'h0003, 16'h4001);
        cmp({fl, fb}, {6'h20, 16'h0000});
        u_seq.wr(`FPA_A_CTRL, 32'h16);
        @(posedge clk);
        #1;
        cmp({fl, fb}, {6'h00, 16'h0007});
        u_seq.wr(`FPA_A_CTRL, 32'h16);
        @(posedge clk);
        #1;
        cmp(fb, 16'h0008);
        u_seq.rd(`FPA_A_YOP, d);
        cmp(d, 32'h000f);
        u_seq.wr(`FPA_A_MODE, 32'h4);
        run(32'h0, 16'h7fff, 16'h0001);
        run(32'h0, 16'h0001, 16'h0001);
        cmp(fl, 6'h04);
        u_seq.wr(`FPA_A_MODE, 32'h8);
        run(32'h0, 16'h7fff, 16'h0001);
        cmp(res, 16'h7fff);
        run(32'h2, 16'h8000, 16'h0001);
        cmp(res, 16'h8000);
        run(32'h20, 16'h7fff, 16'h0001);
        cmp(fb, 16'h8000);
        u_seq.wr(4'h9, 32'h1234);
        u_seq.rd(4'h9, d);
        cmp(d, 32'h0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp({fl, res, fb}, 38'h0);
        u_seq.rd(`FPA_A_MODE, d);
        cmp(d, 32'h0);
        stop_test();
    end
endmodule // tb
`default_nettype wire
